//--- src/strap_pkg.sv
// Functional notes
// - sample clock-drive strap while reset low; capture it when reset releases.
// - weak pull-downs on clock strap pins on during reset, off after capture.
// - latched drive select 0 means 24 MHz crystal, 1 means external 24 MHz clock.
// - sample two-bit frequency strap during reset; latch both bits at release.
// - frequency code 00 means 24 MHz; other codes reserved, board must not strap them.
// - clock choice comes only from captured straps; later pin changes ignored.
package strap_pkg;

    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned RESET_MIN_NS   = 1000;
    // least reset width in core cycles, rounded up
    localparam int unsigned RESET_MIN_CYC  = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RST_CNT_W      = 10;

    localparam logic        DRIVE_CRYSTAL  = 1'b0;
    localparam logic        DRIVE_EXTERNAL = 1'b1;
    localparam logic [1:0]  FREQ_24MHZ     = 2'b00;
    localparam logic [1:0]  FREQ_RESET     = 2'b00;
    localparam int unsigned REF_24MHZ_KHZ  = 24000;

    // captured clock configuration
    typedef struct packed {
        logic       external_clk;   // 1: external oscillator on crystal input
        logic [1:0] freq_code;      // raw latched code
        logic       freq_reserved;  // raw code was reserved
    } clk_cfg_s;

endpackage

//--- src/strap_capture.sv
`timescale 1ns/1ps
// holds the strap values seen in the last reset cycle; sampling runs every
// cycle of reset so the last sample before release is what gets kept
module strap_capture (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       sample_en,
    input  wire logic       drive_in,
    input  wire logic [1:0] freq_in,
    output logic            drive_q,
    output logic [1:0]      freq_q
);

    // track pins only while the window is open, then hold; core reset clears the
    // flops so nothing stale is published if a window is cut short by it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive_q <= strap_pkg::DRIVE_CRYSTAL;
            freq_q  <= strap_pkg::FREQ_RESET;
        end else if (sample_en) begin
            drive_q <= drive_in;
            freq_q  <= freq_in;
        end
    end

endmodule // strap_capture

//--- src/reset_strap_clock_select.sv
`timescale 1ns/1ps
// captures clock straps during the active-low system reset and publishes the
// reference clock choice once the reset is released
module reset_strap_clock_select (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                sys_reset_n,
    input  wire logic                clock_drive_select_strap_i,
    output logic                     clock_drive_select_strap_o,
    output logic                     clock_drive_select_strap_oe,
    input  wire logic [1:0]          freq_select_strap_i,
    output logic [1:0]               freq_select_strap_o,
    output logic [1:0]               freq_select_strap_oe,
    output logic                     strap_pulldown_en,
    output logic                     cfg_valid,
    output strap_pkg::clk_cfg_s      clk_cfg,
    output logic                     use_crystal,
    output logic                     crystal_osc_en,
    output logic                     reset_too_short
);

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_LOCKED  = 2'b10
    } phase_e;

    phase_e                        phase_q;
    phase_e                        phase_d;
    logic                          sample_en;
    logic                          capture_now;
    logic                          drive_raw;
    logic [1:0]                    freq_raw;
    logic [strap_pkg::RST_CNT_W-1:0] low_cnt_q;

    function automatic logic is_reserved(input logic [1:0] code);
        return code != strap_pkg::FREQ_24MHZ;
    endfunction

    // window open while system reset is held low
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            ST_IDLE:   if (!sys_reset_n) phase_d = ST_SAMPLE;
            ST_SAMPLE: if (sys_reset_n)  phase_d = ST_LOCKED;
            ST_LOCKED: if (!sys_reset_n) phase_d = ST_SAMPLE;
            default:   phase_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_q <= ST_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign sample_en = !rst && !sys_reset_n;

    // release edge: straps already sit in the capture flops from the last low cycle
    assign capture_now = (phase_q == ST_SAMPLE) && sys_reset_n;

    strap_capture u_capture (
        .core_clk  (core_clk),
        .rst       (rst),
        .sample_en (sample_en),
        .drive_in  (clock_drive_select_strap_i),
        .freq_in   (freq_select_strap_i),
        .drive_q   (drive_raw),
        .freq_q    (freq_raw)
    );

    // pull-downs on as soon as reset goes low, so even a one-cycle window samples
    // a defined level on an unfitted pin; strap pins are never driven by us
    assign strap_pulldown_en           = !sys_reset_n || (phase_q != ST_LOCKED);
    assign clock_drive_select_strap_o  = 1'h0;
    assign clock_drive_select_strap_oe = 1'h0;

    // output buffers stay disabled on every frequency strap bit
    for (genvar i = 0; i < $bits(freq_select_strap_o); i++) begin : g_freq_pin
        assign freq_select_strap_o[i]  = 1'h0;
        assign freq_select_strap_oe[i] = 1'h0;
    end

    // published config is frozen after release; pins moving later change nothing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clk_cfg   <= '{external_clk: strap_pkg::DRIVE_CRYSTAL,
                           freq_code: strap_pkg::FREQ_RESET, freq_reserved: 1'b0};
            cfg_valid <= 1'b0;
        end else if (capture_now) begin
            clk_cfg.external_clk  <= drive_raw;
            clk_cfg.freq_code     <= freq_raw;
            clk_cfg.freq_reserved <= is_reserved(freq_raw);
            cfg_valid             <= 1'b1;
        end else if (!sys_reset_n) begin
            cfg_valid <= 1'b0;
        end
    end

    // reserved codes still run at 24 MHz, so the oscillator choice uses drive only;
    // registered beside clk_cfg so the oscillator controls never glitch
    always_ff @(posedge core_clk) begin
        if (rst) begin
            use_crystal    <= 1'h1;  // crystal until a window says otherwise
            crystal_osc_en <= 1'h0;
        end else if (capture_now) begin
            use_crystal    <= (drive_raw == strap_pkg::DRIVE_CRYSTAL);
            crystal_osc_en <= (drive_raw == strap_pkg::DRIVE_CRYSTAL);
        end else if (!sys_reset_n) begin
            crystal_osc_en <= 1'h0;  // choice is void while a new window runs
        end
    end

    // flags a reset pulse shorter than the least width; diagnostic only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            low_cnt_q       <= '0;
            reset_too_short <= 1'b0;
        end else if (!sys_reset_n) begin
            if (low_cnt_q != strap_pkg::RESET_MIN_CYC[strap_pkg::RST_CNT_W-1:0]) begin
                low_cnt_q <= low_cnt_q + 1'b1;
            end
        end else if (phase_q == ST_SAMPLE) begin
            reset_too_short <= low_cnt_q < strap_pkg::RESET_MIN_CYC[strap_pkg::RST_CNT_W-1:0];
            low_cnt_q       <= '0;
        end
    end

    // one reset window closing: low on one edge, high on the next
    sequence s_window_close;
        !sys_reset_n ##1 sys_reset_n;
    endsequence

    // the capture edge itself, where the straps go public
    sequence s_release;
        phase_q == ST_SAMPLE && sys_reset_n;
    endsequence

    // a window only one cycle long, entered from released reset
    sequence s_single_low;
        sys_reset_n ##1 !sys_reset_n ##1 sys_reset_n;
    endsequence

    // published values are the pins two edges back, the last low cycle
    a_capture_drive: assert property (@(posedge core_clk) disable iff (rst)
        s_window_close |=> clk_cfg.external_clk == $past(clock_drive_select_strap_i, 2))
        else $error("drive strap not captured at release");
    a_capture_freq: assert property (@(posedge core_clk) disable iff (rst)
        s_window_close |=> clk_cfg.freq_code == $past(freq_select_strap_i, 2))
        else $error("frequency strap not captured at release");
    a_phase_enter: assert property (@(posedge core_clk) disable iff (rst)
        !sys_reset_n |=> phase_q == ST_SAMPLE)
        else $error("window not entered on low reset");
    a_locked_after: assert property (@(posedge core_clk) disable iff (rst)
        s_release |=> phase_q == ST_LOCKED)
        else $error("not locked after release");

    // capture flops follow the pins inside the window and hold outside it
    a_sample_drive: assert property (@(posedge core_clk) disable iff (rst)
        sample_en |=> drive_raw == $past(clock_drive_select_strap_i))
        else $error("drive strap not tracked during reset");
    a_sample_freq: assert property (@(posedge core_clk) disable iff (rst)
        sample_en |=> freq_raw == $past(freq_select_strap_i))
        else $error("frequency strap not tracked during reset");
    a_raw_hold: assert property (@(posedge core_clk) disable iff (rst)
        !sample_en |=> $stable(drive_raw) && $stable(freq_raw))
        else $error("capture flops moved outside the window");

    // pull-downs: on for the whole window and while idle, off once locked
    a_pulldown_window: assert property (@(posedge core_clk) disable iff (rst)
        s_release ##1 sys_reset_n |-> !strap_pulldown_en)
        else $error("pull-down still on after release");
    a_pulldown_reset: assert property (@(posedge core_clk) disable iff (rst)
        !sys_reset_n |-> strap_pulldown_en)
        else $error("pull-down off during reset");
    a_pulldown_locked: assert property (@(posedge core_clk) disable iff (rst)
        cfg_valid && sys_reset_n |-> !strap_pulldown_en)
        else $error("pull-down on while locked");
    a_pulldown_idle: assert property (@(posedge core_clk) disable iff (rst)
        phase_q == ST_IDLE |-> strap_pulldown_en)
        else $error("pull-down off before first window");

    // oscillator controls track the captured drive strap only
    a_drive_mode: assert property (@(posedge core_clk) disable iff (rst)
        cfg_valid |-> use_crystal == !clk_cfg.external_clk)
        else $error("crystal mode mismatch");
    a_osc_enable: assert property (@(posedge core_clk) disable iff (rst)
        s_window_close |=>
            crystal_osc_en == ($past(clock_drive_select_strap_i, 2) == strap_pkg::DRIVE_CRYSTAL))
        else $error("oscillator enable does not follow drive strap");
    a_osc_window: assert property (@(posedge core_clk) disable iff (rst)
        !sys_reset_n |=> !crystal_osc_en)
        else $error("oscillator enabled inside a window");

    // once valid the choice is frozen until the next window
    a_cfg_frozen: assert property (@(posedge core_clk) disable iff (rst)
        (cfg_valid && sys_reset_n) ##1 sys_reset_n |-> $stable(clk_cfg))
        else $error("config changed after release");
    a_valid_release: assert property (@(posedge core_clk) disable iff (rst)
        s_release |=> cfg_valid)
        else $error("config not valid after release");
    a_valid_drop: assert property (@(posedge core_clk) disable iff (rst)
        cfg_valid && !sys_reset_n |=> !cfg_valid)
        else $error("config still valid inside a window");

    // reserved frequency codes run at 24 MHz but stay visible
    a_reserved_flag: assert property (@(posedge core_clk) disable iff (rst)
        cfg_valid |-> clk_cfg.freq_reserved == (clk_cfg.freq_code != strap_pkg::FREQ_24MHZ))
        else $error("reserved flag wrong");

    // reset-width diagnostic: a one-cycle window is always too short
    a_short_pulse: assert property (@(posedge core_clk) disable iff (rst)
        s_single_low |=> reset_too_short)
        else $error("one-cycle reset not flagged");
    a_long_pulse: assert property (@(posedge core_clk) disable iff (rst)
        capture_now && (low_cnt_q == strap_pkg::RESET_MIN_CYC[strap_pkg::RST_CNT_W-1:0])
            |=> !reset_too_short)
        else $error("full-width reset flagged as short");

    // core reset returns every published output to its idle level
    a_rst_defaults: assert property (@(posedge core_clk)
        rst |=> !cfg_valid && !crystal_osc_en && !reset_too_short && strap_pulldown_en)
        else $error("outputs not at defaults after core reset");

endmodule // reset_strap_clock_select

//--- dv/strap_board.sv
`timescale 1ns/1ps
// board side of the straps: resistors where fitted, otherwise open pins
module strap_board (
    input  wire logic       core_clk,
    input  wire logic       fitted,
    input  wire logic       drive_val,
    input  wire logic [1:0] freq_val,
    input  wire logic       pulldown_en,
    output logic            drive_pin,
    output logic [1:0]      freq_pin
);
    logic wander_q = 1'b0;
    // an open pin without its pull-down wanders, so it toggles every cycle
    always @(posedge core_clk) begin
        wander_q <= ~wander_q;
    end
    // the device never drives these pins, so the board alone sets the level
    always_comb begin
        if (fitted) begin
            drive_pin = drive_val;
            freq_pin  = freq_val;
        end else begin
            drive_pin = pulldown_en ? 1'b0 : wander_q;
            freq_pin  = pulldown_en ? 2'b00 : {~wander_q, wander_q};
        end
    end
endmodule // strap_board

//--- dv/reset_strap_clock_select_tb.sv
`timescale 1ns/1ps
module reset_strap_clock_select_tb;
    logic                core_clk = 1'b0;
    logic                rst = 1'b1;
    logic                sys_reset_n = 1'b1;
    logic                fitted = 1'b0;
    logic                drive_val = 1'b0;
    logic [1:0]          freq_val = 2'b00;
    logic                drive_pin, pulldown_en, drv_o, drv_oe, cfg_valid;
    logic                use_crystal, osc_en, too_short;
    logic [1:0]          freq_pin, frq_o, frq_oe;
    strap_pkg::clk_cfg_s clk_cfg;
    int                  failures = 0, compares = 0, cycles = 0, seed = 26;
    int                  exp_q[$];
    strap_board board (.core_clk(core_clk), .fitted(fitted), .drive_val(drive_val),
        .freq_val(freq_val), .pulldown_en(pulldown_en), .drive_pin(drive_pin),
        .freq_pin(freq_pin));
    reset_strap_clock_select uut (.core_clk(core_clk), .rst(rst), .sys_reset_n(sys_reset_n),
        .clock_drive_select_strap_i(drive_pin), .clock_drive_select_strap_o(drv_o),
        .clock_drive_select_strap_oe(drv_oe), .freq_select_strap_i(freq_pin),
        .freq_select_strap_o(frq_o), .freq_select_strap_oe(frq_oe),
        .strap_pulldown_en(pulldown_en), .cfg_valid(cfg_valid), .clk_cfg(clk_cfg),
        .use_crystal(use_crystal), .crystal_osc_en(osc_en), .reset_too_short(too_short));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // hang guard: the whole run needs well under this many cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    task automatic results();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one low pulse of the system reset, then the published choice is compared
    task automatic pulse(input int low, input logic f, input logic d, input logic [1:0] c);
        int drv, frq, shrt;
        drv  = f ? d : 0;
        frq  = f ? c : 0;
        shrt = (low < strap_pkg::RESET_MIN_CYC);
        // model entry: what this window must publish, kept until the pins have moved
        exp_q.push_back(drv + 2 * frq + 8 * shrt);
        fitted = f;
        drive_val = d;
        freq_val = c;
        sys_reset_n = 1'b0;
        repeat (low) @(negedge core_clk);
        check(8'(pulldown_en), 8'h01);
        check(8'(cfg_valid), 8'h00);
        sys_reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        // later pin changes must leave the captured choice alone
        for (int k = 0; k < 2; k++) begin
            check(8'({cfg_valid, clk_cfg.external_clk, use_crystal, osc_en}),
                8'({1'b1, drv[0], ~drv[0], ~drv[0]}));
            check(8'({clk_cfg.freq_code, clk_cfg.freq_reserved}),
                8'({frq[1:0], frq != 0}));
            check(8'({too_short, pulldown_en}), 8'({shrt[0], 1'b0}));
            check(8'({drv_o, drv_oe, frq_o, frq_oe}), 8'h00);
            fitted = 1'b1;
            drive_val = ~drv[0];
            freq_val = 2'($random(seed));
            repeat (3) @(negedge core_clk);
        end
        check(8'({too_short, clk_cfg.freq_code, clk_cfg.external_clk}), 8'(exp_q.pop_front()));
        $display("pulse of %0d cycles done", low);
    endtask
    initial begin
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        pulse(250, 1'b0, 1'b1, 2'b11);
        for (int k = 0; k < 8; k++) begin
            pulse(k == 0 ? 1 : (k == 7 ? 249 : 250), 1'b1, k[0], k[2:1]);
        end
        for (int k = 0; k < 6; k++) begin
            pulse(1 + {$random(seed)} % 300, 1'b1, 1'($random(seed)), 2'($random(seed)));
        end
        // unfitted one-cycle window straight from lock: pull-downs must act at once
        pulse(1, 1'b0, 1'b1, 2'b11);
        // core reset mid-run drops the published choice back to its defaults
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        check(8'({cfg_valid, osc_en, too_short, pulldown_en, use_crystal}), 8'h03);
        check(8'(clk_cfg), 8'h00);
        rst = 1'b0;
        pulse(2, 1'b1, 1'b1, 2'b01);
        results();
    end
endmodule // reset_strap_clock_select_tb
